// >>> verilog/flash_host_ctrl.sv
// The Wishbone interface to the registers and the register offsets were decided locally.
`include "flash_host_consts.svh"
`default_nettype none
module flash_host_ctrl
    import flash_host_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Interrupt
    output logic irq,
    // Flash pins
    output logic [17:0] flAddr,
    output logic flCeN,
    output logic flOeN,
    output logic flWeN,
    output logic flWordMode,
    output logic [15:0] flDqOut,
    output logic [15:0] flDqOe,
    input wire logic [15:0] flDqIn,
    input wire logic readyBusyOut
);
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_WRITE = 7'b0000010,
        S_WWAIT = 7'b0000100,
        S_READ = 7'b0001000,
        S_RWAIT = 7'b0010000,
        S_RECOVER = 7'b0100000,
        S_RBWAIT = 7'b1000000
    } state_t;

    flash_cyc_if cycU ();

    state_t st_q;
    op_t op_q;
    logic [2:0] step_q;
    logic [18:0] addr_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic byteMode_q;
    logic flashActive_q;
    logic prevToggle_q;
    logic havePrev_q;
    logic doneEv_q;
    logic [11:0] cnt_q;
    logic [11:0] winCnt_q;
    logic [2:0] irqStat_q;
    logic [2:0] irqStat_d;
    logic [2:0] irqMask_q;
    logic rbMeta_q;
    logic rbSync_q;
    logic wbTake;
    logic startReq;
    logic refusedEv;
    logic seqEnd;
    logic winCloseEv;
    logic [31:0] rdMux;
    op_t opReq;
    step_t curStep;

    // Number of flash write cycles for each operation
    function automatic logic [2:0] seqLen(input op_t op);
        unique case (op)
            OP_READ, OP_POLL, OP_RB_WAIT: seqLen = 3'd0;
            OP_RESET_SHORT, OP_ADD_BLOCK, OP_SUSPEND, OP_RESUME: seqLen = 3'd1;
            OP_RESET_LONG, OP_AUTOSEL: seqLen = 3'd3;
            OP_PROGRAM: seqLen = 3'd4;
            OP_BLOCK_ERASE, OP_CHIP_ERASE: seqLen = 3'd6;
            default: seqLen = 3'd0;
        endcase
    endfunction : seqLen

    // What goes on the bus at a given write step
    function automatic step_t stepOf(input op_t op, input logic [2:0] idx);
        step_t s;
        s = '{K_UNLOCK1, `FL_UNLOCK_DATA1};
        if (op == OP_RESET_SHORT) begin
            s = '{K_CMDT, `FL_CMD_RESET}; // [R2]
        end else if (op == OP_SUSPEND) begin
            s = '{K_CMDT, `FL_CMD_SUSPEND}; // [R9]
        end else if (op == OP_ADD_BLOCK || op == OP_RESUME) begin
            s = '{K_CMDT, `FL_CMD_ERASE_CONF}; // [R7] [R10]
        end else if (op == OP_PROGRAM && idx == 3'd3) begin
            s = '{K_DATA, 8'h00}; // [R6]
        end else if (idx == 3'd1 || idx == 3'd4) begin
            s = '{K_UNLOCK2, `FL_UNLOCK_DATA2}; // [R1]
        end else if (idx == 3'd2) begin
            unique case (op)
                OP_RESET_LONG: s = '{K_CMDU, `FL_CMD_RESET}; // [R2]
                OP_AUTOSEL: s = '{K_CMDU, `FL_CMD_AUTOSEL}; // [R4]
                OP_PROGRAM: s = '{K_CMDU, `FL_CMD_PROGRAM}; // [R6]
                default: s = '{K_CMDU, `FL_CMD_ERASE_SETUP}; // [R7] [R8]
            endcase
        end else if (idx == 3'd5) begin
            if (op == OP_CHIP_ERASE) begin
                s = '{K_CMDU, `FL_CMD_CHIP_CONF}; // [R8]
            end else begin
                s = '{K_CMDT, `FL_CMD_ERASE_CONF}; // [R7]
            end
        end
        return s;
    endfunction : stepOf

    // Maps byte or word address to pins, byte bit lowest
    function automatic logic [18:0] pinAddr(input logic [18:0] a, input logic byteMode);
        pinAddr = byteMode ? a : {a[17:0], 1'b0};
    endfunction : pinAddr

    flash_bus_cycle u_cycle (
        .core_clk(core_clk),
        .rst(rst),
        .cyc(cycU.engine),
        .flAddr(flAddr),
        .flCeN(flCeN),
        .flOeN(flOeN),
        .flWeN(flWeN),
        .flDqOut(flDqOut),
        .flDqOe(flDqOe),
        .flDqIn(flDqIn)
    );

    // Bus decode and request checks
    always_comb begin
        wbTake = cyc_i && stb_i && !ack_o;
        opReq = op_t'(dat_i[3:0]);
        startReq = wbTake && we_i && sel_i[0] && adr_i == `REG_CTRL;
        // Late block additions are refused: the window may have closed
        refusedEv = startReq && (st_q != S_IDLE || opReq > OP_RB_WAIT
            || (opReq == OP_ADD_BLOCK && winCnt_q == 12'h000)); // [R7]
        curStep = stepOf(op_q, step_q);
        seqEnd = st_q == S_WWAIT && cycU.done && step_q == seqLen(op_q) - 3'd1;
        winCloseEv = winCnt_q == 12'h001;
    end

    // Register read mux
    always_comb begin
        unique case (adr_i)
            `REG_CTRL: rdMux = {27'h0, byteMode_q, op_q};
            `REG_ADDR: rdMux = {13'h0, addr_q};
            `REG_WDATA: rdMux = {16'h0, wdata_q};
            `REG_STATUS: rdMux = {rdata_q, 12'h0, flashActive_q, winCnt_q != 12'h000, rbSync_q, st_q != S_IDLE};
            `REG_IRQ_STAT: rdMux = {29'h0, irqStat_q};
            `REG_IRQ_MASK: rdMux = {29'h0, irqMask_q};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // Registered ack, one wait state; writes land with the ack
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= wbTake;
            if (wbTake && !we_i) begin
                dat_o <= rdMux;
            end
        end
    end

    // Software-held parameters of the next operation
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            addr_q <= 19'h00000;
            wdata_q <= 16'h0000;
            byteMode_q <= 1'b0;
            irqMask_q <= 3'h0;
            flWordMode <= 1'b1;
        end else begin
            if (wbTake && we_i) begin
                if (adr_i == `REG_ADDR) begin
                    if (sel_i[0]) addr_q[7:0] <= dat_i[7:0];
                    if (sel_i[1]) addr_q[15:8] <= dat_i[15:8];
                    if (sel_i[2]) addr_q[18:16] <= dat_i[18:16];
                end
                if (adr_i == `REG_WDATA) begin
                    if (sel_i[0]) wdata_q[7:0] <= dat_i[7:0];
                    if (sel_i[1]) wdata_q[15:8] <= dat_i[15:8];
                end
                if (adr_i == `REG_IRQ_MASK && sel_i[0]) begin
                    irqMask_q <= dat_i[2:0];
                end
                // Bus width may only change while idle
                if (startReq && st_q == S_IDLE) begin
                    byteMode_q <= dat_i[`CTRL_BYTE_BIT];
                    flWordMode <= !dat_i[`CTRL_BYTE_BIT];
                end
            end
        end
    end

    // Ready/busy pin comes from outside the clock domain
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rbMeta_q <= 1'b0;
            rbSync_q <= 1'b0;
        end else begin
            rbMeta_q <= readyBusyOut;
            rbSync_q <= rbMeta_q;
        end
    end

    // Block-add window, host side uses the short end of the timeout
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            winCnt_q <= 12'h000;
        end else if (seqEnd && (op_q == OP_BLOCK_ERASE || op_q == OP_ADD_BLOCK)) begin
            winCnt_q <= 12'(`FL_WIN_CYC); // [R7] [R15]
        end else if (winCnt_q != 12'h000) begin
            winCnt_q <= winCnt_q - 12'h001;
        end
    end

    // Command sequencer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= S_IDLE;
            op_q <= OP_READ;
            step_q <= 3'd0;
            rdata_q <= 16'h0000;
            flashActive_q <= 1'b0;
            prevToggle_q <= 1'b0;
            havePrev_q <= 1'b0;
            doneEv_q <= 1'b0;
            cnt_q <= 12'h000;
            cycU.req <= 1'b0;
            cycU.we <= 1'b0;
            cycU.byteMode <= 1'b0;
            cycU.aLow <= 1'b0;
            cycU.addr <= 18'h00000;
            cycU.wdata <= 16'h0000;
        end else begin
            cycU.req <= 1'b0;
            doneEv_q <= 1'b0;
            unique case (st_q)
                S_IDLE: begin
                    if (startReq && !refusedEv) begin
                        op_q <= opReq;
                        step_q <= 3'd0;
                        havePrev_q <= 1'b0;
                        if (opReq == OP_READ || opReq == OP_POLL) begin
                            st_q <= S_READ;
                        end else if (opReq == OP_RB_WAIT) begin
                            st_q <= S_RBWAIT; // [R11]
                        end else begin
                            st_q <= S_WRITE;
                        end
                    end
                end
                S_WRITE: begin
                    cycU.req <= 1'b1;
                    cycU.we <= 1'b1;
                    cycU.byteMode <= byteMode_q;
                    cycU.wdata <= {8'h00, curStep.cmd};
                    // Coded cycles keep the upper three address bits low
                    unique case (curStep.kind)
                        K_UNLOCK1: {cycU.addr, cycU.aLow} <= (byteMode_q ? `FL_UNLOCK1_BYTE
                            : `FL_UNLOCK1_WORD) & `FL_CODED_KEEP; // [R1]
                        K_UNLOCK2: {cycU.addr, cycU.aLow} <= (byteMode_q ? `FL_UNLOCK2_BYTE
                            : `FL_UNLOCK2_WORD) & `FL_CODED_KEEP; // [R1]
                        K_CMDU: {cycU.addr, cycU.aLow} <= (byteMode_q ? `FL_UNLOCK1_BYTE
                            : `FL_UNLOCK1_WORD) & `FL_CODED_KEEP;
                        default: {cycU.addr, cycU.aLow} <= pinAddr(addr_q, byteMode_q);
                    endcase
                    if (curStep.kind == K_DATA) begin
                        cycU.wdata <= wdata_q; // [R6]
                    end
                    st_q <= S_WWAIT;
                end
                S_WWAIT: begin
                    if (cycU.done) begin
                        step_q <= step_q + 3'd1;
                        st_q <= S_WRITE;
                        if (seqEnd) begin
                            unique case (op_q)
                                OP_PROGRAM, OP_CHIP_ERASE, OP_RESUME: begin
                                    flashActive_q <= 1'b1;
                                    st_q <= S_READ; // [R6] [R8] [R10]
                                end
                                OP_SUSPEND: st_q <= S_READ; // [R9]
                                OP_BLOCK_ERASE, OP_ADD_BLOCK: begin
                                    flashActive_q <= 1'b1;
                                    doneEv_q <= 1'b1;
                                    st_q <= S_IDLE; // [R7]
                                end
                                OP_RESET_SHORT, OP_RESET_LONG: begin
                                    // Reset while working costs the reset-to-ready wait
                                    if (flashActive_q) begin
                                        cnt_q <= 12'(`FL_RST_RDY_CYC); // [R13]
                                        st_q <= S_RECOVER;
                                    end else begin
                                        doneEv_q <= 1'b1;
                                        st_q <= S_IDLE; // [R2] [R3]
                                    end
                                end
                                default: begin
                                    doneEv_q <= 1'b1;
                                    st_q <= S_IDLE; // [R3] [R4] [R5]
                                end
                            endcase
                        end
                    end
                end
                S_READ: begin
                    cycU.req <= 1'b1;
                    cycU.we <= 1'b0;
                    cycU.byteMode <= byteMode_q;
                    {cycU.addr, cycU.aLow} <= pinAddr(addr_q, byteMode_q); // [R4] [R5]
                    st_q <= S_RWAIT;
                end
                S_RWAIT: begin
                    if (cycU.done) begin
                        rdata_q <= cycU.rdata; // [R3] [R14]
                        prevToggle_q <= cycU.rdata[`FL_TOGGLE_BIT];
                        havePrev_q <= 1'b1;
                        // Two equal toggle reads mean the operation is over
                        if (op_q == OP_READ || (havePrev_q && prevToggle_q == cycU.rdata[`FL_TOGGLE_BIT])) begin
                            if (op_q != OP_READ && op_q != OP_SUSPEND) begin
                                flashActive_q <= 1'b0; // [R16]
                            end
                            doneEv_q <= 1'b1;
                            st_q <= S_IDLE;
                        end else begin
                            st_q <= S_READ; // [R6] [R14]
                        end
                    end
                end
                S_RECOVER: begin
                    if (cnt_q == 12'h000) begin
                        flashActive_q <= 1'b0;
                        doneEv_q <= 1'b1;
                        st_q <= S_IDLE; // [R13]
                    end else begin
                        cnt_q <= cnt_q - 12'h001;
                    end
                end
                S_RBWAIT: begin
                    if (rbSync_q) begin
                        flashActive_q <= 1'b0;
                        doneEv_q <= 1'b1;
                        st_q <= S_IDLE; // [R11]
                    end
                end
            endcase
        end
    end

    // Sticky events; a new event beats the read clear
    always_comb begin
        irqStat_d = irqStat_q;
        if (wbTake && !we_i && adr_i == `REG_IRQ_STAT) begin
            irqStat_d = 3'h0;
        end
        irqStat_d[`IRQ_DONE_BIT] = irqStat_d[`IRQ_DONE_BIT] | doneEv_q;
        irqStat_d[`IRQ_REFUSED_BIT] = irqStat_d[`IRQ_REFUSED_BIT] | refusedEv;
        irqStat_d[`IRQ_WINDOW_BIT] = irqStat_d[`IRQ_WINDOW_BIT] | winCloseEv;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irqStat_q <= 3'h0;
            irq <= 1'b0;
        end else begin
            irqStat_q <= irqStat_d;
            irq <= |(irqStat_d & irqMask_q);
        end
    end
endmodule : flash_host_ctrl
`default_nettype wire

// >>> verilog/flash_host_consts.svh
// Overview of operation
// [R1] Unlock is AA then 55 at mode addresses
// [R2] F0 returns device to array reads
// [R3] Reads after read/auto-select commands repeat freely
// [R4] Auto-select: address bits pick signature codes
// [R5] Auto-select: block address reads protection status
// [R6] Program: unlock, A0, data, then poll
// [R7] Block erase; more blocks inside timeout window
// [R8] Chip erase: unlock, 80, unlock, 10, poll
// [R9] B0 suspends erase; other blocks stay usable
// [R10] 30 resumes suspended erase, then poll
// [R11] Ready/busy pin may signal erase completion
// [R12] Unknown sequences leave device in array reads
// [R13] Reset during operation needs reset-to-ready wait
// [R14] Reads during operation return status bits
// [R15] Erase timer flag rises 80-120 us later
// [R16] Finished operation returns to array reads
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH

// Command bytes
`define FL_UNLOCK_DATA1 8'hAA
`define FL_UNLOCK_DATA2 8'h55
`define FL_CMD_RESET 8'hF0
`define FL_CMD_AUTOSEL 8'h90
`define FL_CMD_PROGRAM 8'hA0
`define FL_CMD_ERASE_SETUP 8'h80
`define FL_CMD_ERASE_CONF 8'h30
`define FL_CMD_CHIP_CONF 8'h10
`define FL_CMD_SUSPEND 8'hB0

// Coded addresses, byte bit lowest
`define FL_UNLOCK1_WORD 19'h0AAAA
`define FL_UNLOCK2_WORD 19'h05554
`define FL_UNLOCK1_BYTE 19'h0AAAA
`define FL_UNLOCK2_BYTE 19'h05555
`define FL_CODED_KEEP 19'h0FFFF
`define FL_TOGGLE_BIT 6

// Operation codes in the control register
`define OP_READ 4'h0
`define OP_RESET_SHORT 4'h1
`define OP_RESET_LONG 4'h2
`define OP_AUTOSEL 4'h3
`define OP_PROGRAM 4'h4
`define OP_BLOCK_ERASE 4'h5
`define OP_ADD_BLOCK 4'h6
`define OP_CHIP_ERASE 4'h7
`define OP_SUSPEND 4'h8
`define OP_RESUME 4'h9
`define OP_POLL 4'hA
`define OP_RB_WAIT 4'hB

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_STATUS 8'h0C
`define REG_IRQ_STAT 8'h10
`define REG_IRQ_MASK 8'h14
`define CTRL_BYTE_BIT 4
`define IRQ_DONE_BIT 0
`define IRQ_REFUSED_BIT 1
`define IRQ_WINDOW_BIT 2

// Timing
`define FL_CLK_NS 25
`define FL_WE_NS 35
`define FL_ACC_NS 55
`define FL_SYNC_CYC 2
`define FL_WIN_NS 80000
`define FL_RST_RDY_NS 10000
`define FL_WE_CYC ((`FL_WE_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)
`define FL_RD_CYC ((`FL_ACC_NS + `FL_CLK_NS - 1) / `FL_CLK_NS + `FL_SYNC_CYC)
`define FL_WIN_CYC (`FL_WIN_NS / `FL_CLK_NS)
`define FL_RST_RDY_CYC ((`FL_RST_RDY_NS + `FL_CLK_NS - 1) / `FL_CLK_NS)

`endif

// >>> verilog/flash_host_pkg.sv
`include "flash_host_consts.svh"
`default_nettype none
package flash_host_pkg;
    typedef enum logic [3:0] {
        OP_READ = `OP_READ,
        OP_RESET_SHORT = `OP_RESET_SHORT,
        OP_RESET_LONG = `OP_RESET_LONG,
        OP_AUTOSEL = `OP_AUTOSEL,
        OP_PROGRAM = `OP_PROGRAM,
        OP_BLOCK_ERASE = `OP_BLOCK_ERASE,
        OP_ADD_BLOCK = `OP_ADD_BLOCK,
        OP_CHIP_ERASE = `OP_CHIP_ERASE,
        OP_SUSPEND = `OP_SUSPEND,
        OP_RESUME = `OP_RESUME,
        OP_POLL = `OP_POLL,
        OP_RB_WAIT = `OP_RB_WAIT
    } op_t;

    typedef enum logic [2:0] {K_UNLOCK1, K_UNLOCK2, K_CMDU, K_CMDT, K_DATA} step_kind_t;

    typedef struct packed {
        step_kind_t kind;
        logic [7:0] cmd;
    } step_t;
endpackage : flash_host_pkg
`default_nettype wire

// >>> verilog/flash_cyc_if.sv
`default_nettype none
interface flash_cyc_if;
    logic req;
    logic we;
    logic byteMode;
    logic aLow;
    logic [17:0] addr;
    logic [15:0] wdata;
    logic done;
    logic [15:0] rdata;
    modport engine(input req, we, byteMode, aLow, addr, wdata, output done, rdata);
    modport user(output req, we, byteMode, aLow, addr, wdata, input done, rdata);
endinterface : flash_cyc_if
`default_nettype wire

// >>> verilog/flash_bus_cycle.sv
`include "flash_host_consts.svh"
`default_nettype none
module flash_bus_cycle
    import flash_host_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Cycle requests
    flash_cyc_if.engine cyc,
    // Flash pins
    output logic [17:0] flAddr,
    output logic flCeN,
    output logic flOeN,
    output logic flWeN,
    output logic [15:0] flDqOut,
    output logic [15:0] flDqOe,
    input wire logic [15:0] flDqIn
);
    typedef enum logic [3:0] {
        CY_IDLE = 4'b0001,
        CY_SETUP = 4'b0010,
        CY_STROBE = 4'b0100,
        CY_HOLD = 4'b1000
    } cyc_state_t;

    cyc_state_t st_q;
    logic [3:0] cnt_q;
    logic weCyc_q;
    logic [15:0] dqMeta_q;
    logic [15:0] dqSync_q;

    // Data pins come from outside the clock domain
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dqMeta_q <= 16'h0000;
            dqSync_q <= 16'h0000;
        end else begin
            dqMeta_q <= flDqIn;
            dqSync_q <= dqMeta_q;
        end
    end

    // One pin cycle: setup, strobe, hold
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= CY_IDLE;
            cnt_q <= 4'h0;
            weCyc_q <= 1'b0;
            flAddr <= 18'h00000;
            flCeN <= 1'b1;
            flOeN <= 1'b1;
            flWeN <= 1'b1;
            flDqOut <= 16'h0000;
            flDqOe <= 16'h0000;
            cyc.done <= 1'b0;
            cyc.rdata <= 16'h0000;
        end else begin
            cyc.done <= 1'b0;
            unique case (st_q)
                CY_IDLE: begin
                    if (cyc.req) begin
                        weCyc_q <= cyc.we;
                        flAddr <= cyc.addr;
                        flCeN <= 1'b0;
                        // Byte mode: top data pin carries the extra address bit
                        if (cyc.byteMode) begin
                            flDqOut <= {cyc.aLow, 7'h00, cyc.wdata[7:0]};
                            flDqOe <= cyc.we ? 16'h80FF : 16'h8000;
                        end else begin
                            flDqOut <= cyc.wdata;
                            flDqOe <= cyc.we ? 16'hFFFF : 16'h0000;
                        end
                        st_q <= CY_SETUP;
                    end
                end
                CY_SETUP: begin
                    if (weCyc_q) begin
                        flWeN <= 1'b0;
                        cnt_q <= 4'(`FL_WE_CYC - 1);
                    end else begin
                        flOeN <= 1'b0;
                        cnt_q <= 4'(`FL_RD_CYC - 1);
                    end
                    st_q <= CY_STROBE;
                end
                CY_STROBE: begin
                    if (cnt_q == 4'h0) begin
                        // Sync delay is folded into the read strobe length
                        if (!weCyc_q) begin
                            cyc.rdata <= dqSync_q;
                        end
                        flWeN <= 1'b1;
                        flOeN <= 1'b1;
                        st_q <= CY_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                CY_HOLD: begin
                    flCeN <= 1'b1;
                    flDqOe <= 16'h0000;
                    cyc.done <= 1'b1;
                    st_q <= CY_IDLE;
                end
            endcase
        end
    end
endmodule : flash_bus_cycle
`default_nettype wire

// >>> dv/flash_host_ctrl_props.sv
`default_nettype none
module flash_host_ctrl_props (
    // Watched ports
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic [17:0] flAddr,
    input wire logic flCeN,
    input wire logic flOeN,
    input wire logic flWeN,
    input wire logic [15:0] flDqOe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Bus answer and pin strobe shapes
    AST_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    AST_ACK_ONE: assert property (ack_o |=> !ack_o) else $error("ack too long");
    AST_WE_CE: assert property (!flWeN |-> !flCeN) else $error("write strobe unselected");
    AST_WE_LEN: assert property ($fell(flWeN) |-> !flWeN[*2] ##1 flWeN) else $error("write width");
    AST_OE_LEN: assert property ($fell(flOeN) |-> !flOeN[*5] ##1 flOeN) else $error("read width");
    AST_EXCL: assert property (flOeN || flWeN) else $error("both strobes low");
    AST_WDRV: assert property (!flWeN |-> flDqOe[7:0] == 8'hFF) else $error("data not driven");
    AST_RFREE: assert property (!flOeN |-> flDqOe[14:0] == 15'h0000) else $error("drive during read");
    AST_ADDR: assert property (!flWeN |-> $stable(flAddr)) else $error("address moved");
endmodule : flash_host_ctrl_props
`default_nettype wire

// >>> dv/flash_dev_model.sv
`default_nettype none
module flash_dev_model #(
    parameter logic [7:0] MAKER = 8'h5A, // Arbitrary value
    parameter logic [7:0] DEVID = 8'hC3 // Arbitrary value
) (
    // Pins
    input wire logic [17:0] flAddr,
    input wire logic flCeN,
    input wire logic flOeN,
    input wire logic flWeN,
    input wire logic [15:0] flDqOut,
    output logic [15:0] flDqIn,
    output logic readyBusyOut
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [logic [17:0]];
    logic [7:0] d;
    int seq = 0, busy = 0;
    logic autoSel = 0, prog = 0, setup = 0, tgl = 0;
    assign readyBusyOut = (busy == 0);
    // Command decoding at the write strobe release; top three bits ignored
    always @(posedge flWeN) if (!flCeN) begin
        d = flDqOut[7:0];
        if (prog) begin mem[flAddr] = flDqOut; prog = 0; busy = 6; end
        else if (busy != 0 && d == 8'hB0) busy = 0;
        else if (seq == 0 && d == 8'hAA && flAddr[14:0] == 15'h5555) seq = 1;
        else if (seq == 1 && d == 8'h55 && flAddr[14:0] == 15'h2AAA) seq = 2;
        else if (seq == 2) begin
            seq = 0;
            autoSel = (d == 8'h90);
            prog = (d == 8'hA0);
            if (setup && (d == 8'h30 || d == 8'h10)) begin busy = 8; mem.delete(); end
            setup = (d == 8'h80);
        end else begin seq = 0; autoSel = 0; setup = 0; end
    end
    // Status while busy, signature in auto-select, array otherwise
    always @(negedge flOeN) begin
        tgl = !tgl;
        if (busy != 0) begin busy--; flDqIn = {9'h000, tgl, 2'h0, 1'b1, 3'h0}; end
        else if (autoSel) flDqIn = {8'h00, flAddr[1:0] == 2'b00 ? MAKER : flAddr[1:0] == 2'b01 ? DEVID : 8'h00};
        else flDqIn = mem.exists(flAddr) ? mem[flAddr] : 16'hFFFF;
    end
    // Released bus never shows the old value
    always @(posedge flOeN) flDqIn = ~flDqIn;
endmodule : flash_dev_model
`default_nettype wire

// >>> dv/flash_command_sequence_decoder_bench.sv
`default_nettype none
module flash_command_sequence_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, irq, ceN, oeN, weN, rdy;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat, q;
    logic [17:0] fa;
    logic [15:0] dqo, dqe, dqi;
    int numErrors = 0, checks = 0;
    logic [51:0] rows [11] = '{{4'h4, 16'h0100, 16'h1234, 16'h0}, {4'h0, 16'h0100, 16'h0, 16'h1234},
        {4'h3, 16'h0, 16'h0, 16'h0}, {4'h0, 16'h0, 16'h0, 16'h005A}, {4'h0, 16'h1, 16'h0, 16'h00C3},
        {4'h0, 16'h2, 16'h0, 16'h0}, {4'h2, 16'h0, 16'h0, 16'h0}, {4'h0, 16'h0100, 16'h0, 16'h1234},
        {4'h5, 16'h0100, 16'h0, 16'h0}, {4'h7, 16'h0, 16'h0, 16'h0}, {4'h0, 16'h0100, 16'h0, 16'hFFFF}};
    always #12.5 core_clk = !core_clk;
    flash_host_ctrl dut (.core_clk, .rst, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(dat),
        .sel_i(4'hF), .dat_o(rdat), .ack_o(ack), .irq, .flAddr(fa), .flCeN(ceN), .flOeN(oeN), .flWeN(weN),
        .flWordMode(), .flDqOut(dqo), .flDqOe(dqe), .flDqIn(dqi), .readyBusyOut(rdy));
    flash_dev_model dev (.flAddr(fa), .flCeN(ceN), .flOeN(oeN), .flWeN(weN), .flDqOut(dqo), .flDqIn(dqi),
        .readyBusyOut(rdy));
    task automatic summarize();
        if (numErrors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
        do begin @(posedge core_clk); n++; end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n >= 50) begin numErrors++; summarize(); end
        cyc <= 0; stb <= 0;
        @(posedge core_clk);
    endtask : wb
    // Start an operation and poll busy with a bound
    task automatic run(input logic [3:0] op, input logic [15:0] a, input logic [15:0] d);
        int n;
        n = 0;
        wb(1, 8'h04, {16'h0, a}); wb(1, 8'h08, {16'h0, d}); wb(1, 8'h00, {28'h0, op});
        do begin wb(0, 8'h0C, 32'h0); n++; end while (q[0] !== 1'b0 && n < 3000);
        if (n >= 3000) begin numErrors++; summarize(); end
    endtask : run
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 0;
        @(posedge core_clk);
        foreach (rows[i]) begin
            run(rows[i][51:48], rows[i][47:32], rows[i][31:16]);
            if (rows[i][51:48] == 4'h0) chk(q[31:16], rows[i][15:0]);
        end
        repeat (3300) @(posedge core_clk);
        run(4'h6, 16'h0200, 16'h0); // Window closed
        chk({31'h0, irq}, 32'h0);
        wb(1, 8'h14, 32'h7);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        wb(0, 8'h10, 32'h0);
        chk(q & 32'h3, 32'h3);
        wb(0, 8'h10, 32'h0);
        chk(q, 32'h0);
        wb(0, 8'hFC, 32'h0);
        chk(q, 32'h0);
        rst <= 1;
        @(posedge core_clk);
        rst <= 0;
        chk({ceN, oeN, weN, irq}, 32'hE);
        summarize();
    end
endmodule : flash_command_sequence_decoder_bench
bind flash_host_ctrl flash_host_ctrl_props props (.core_clk, .rst, .cyc_i, .stb_i, .ack_o, .flAddr, .flCeN,
    .flOeN, .flWeN, .flDqOe);
`default_nettype wire
